// ### fnd_frac_mod.sv
// First-order fractional accumulator that picks the feedback divide value per reference tick.
// It assumes the tick is a one-cycle pulse in the pclk domain and that the numerator
// never exceeds the denominator.
`timescale 1ns/100ps
module fnd_frac_mod (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; state holds while low.
  input wire logic tick, // Phase detector tick.
  input wire fnd_pkg::fnd_mod_cfg_t cfg, // Divider settings.
  input wire logic fsk_step, // Adds one to the divide value.
  output logic [17:0] n_eff // Divide value for the coming cycle.
);

  logic [21:0] acc;
  logic [22:0] sum;
  logic carry;

  // Accumulate the numerator; a sum that reaches or passes the denominator borrows one extra count.
  assign sum = {1'b0, acc} + {1'b0, cfg.num};
  assign carry = (cfg.den != 22'h00_0000) && (sum >= {1'b0, cfg.den});

  // The accumulator averages the carries to num/den over successive ticks.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc <= 22'h00_0000;
    else if (ce && tick && cfg.frac_mode)
      acc <= carry ? 22'(sum - {1'b0, cfg.den}) : sum[21:0];
  end

  // Fractional mode looks at the low twelve bits only; integer mode uses all eighteen.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      n_eff <= fnd_pkg::RESET_N;
    else if (ce && tick)
    begin
      if (cfg.frac_mode)
        n_eff <= {6'h00, cfg.n_div[11:0]} + {17'h0_0000, carry} + {17'h0_0000, fsk_step};
      else
        n_eff <= cfg.n_div + {17'h0_0000, fsk_step};
    end
  end

  a_int_divide: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tick && !cfg.frac_mode |=> n_eff == 18'($past(cfg.n_div) + $past(fsk_step)))
    else $error("Integer divide value not taken whole.");

  a_frac_upper: assert property (@(posedge pclk) disable iff (!presetn)
    ce && tick && cfg.frac_mode |=> n_eff <= 18'h0_1001)
    else $error("Fractional divide value used upper bits.");

  a_acc_bound: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.frac_mode && cfg.den != 22'h00_0000 && cfg.num <= cfg.den && acc < cfg.den
    && $stable(cfg) |=> acc < $past(cfg.den))
    else $error("Fraction accumulator left its range.");

endmodule

// ### fnd_host_model.sv
// Host model that runs one APB transfer for each go request from the bench.
// It assumes the slave shares pclk and the active-low asynchronous reset.
`timescale 1ns/100ps
module fnd_host_model (
  input wire logic pclk, // Bus clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic go, // Start one transfer.
  input wire logic wr, // Transfer is a write.
  input wire logic [7:0] addr, // Byte address.
  input wire logic [31:0] wdata, // Write data.
  input wire logic pready, // Slave ready.
  input wire logic [31:0] prdata, // Slave read data.
  input wire logic pslverr, // Slave error.
  output logic psel, // APB select.
  output logic penable, // APB access phase.
  output logic pwrite, // APB direction.
  output logic [7:0] paddr, // APB address.
  output logic [31:0] pwdata, // APB write data.
  output logic done, // Stays high until the next go.
  output logic [31:0] rdata, // Read data taken at completion.
  output logic err // Error taken at completion.
);
  // Setup, then access held until pready is high at an edge; released address and write data are inverted.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0000_0000;
      done <= 1'b0;
      rdata <= 32'h0000_0000;
      err <= 1'b0;
    end
    else if (go)
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      done <= 1'b0;
    end
    else if (psel && !penable)
      penable <= 1'b1;
    else if (psel && pready)
    begin
      rdata <= prdata;
      err <= pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
      done <= 1'b1;
    end
  end
endmodule

// ### fnd_pkg.sv
// Package for the fractional-N divider configuration block.
// It holds the register map, the field positions, the reset values, the limits and the timing.
// It assumes a 20 MHz APB clock and a 32-bit APB data path.
package fnd_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] ADDR_WORD0 = 8'h00;
  localparam logic [7:0] ADDR_WORD1 = 8'h04;
  localparam logic [7:0] ADDR_WORD2 = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Field positions inside the program, control and status words.
  localparam int W0_NUM_LO_LSB = 0;
  localparam int W0_N_LO_LSB = 16;
  localparam int W1_R_LSB = 0;
  localparam int W1_N_HI_LSB = 12;
  localparam int W1_NUM_HI_LSB = 18;
  localparam int W2_DEN_LSB = 0;
  localparam int CTRL_ORDER_LSB = 0;
  localparam int CTRL_DOUBLER_BIT = 3;
  localparam int CTRL_INT_VCO_BIT = 4;
  localparam int CTRL_FSK_BIT = 5;
  localparam int STAT_CAL_BIT = 0;
  localparam int STAT_ERR_BIT = 1;

  // Reset values; the divider resets to one so that it never sits in its illegal state.
  localparam logic [11:0] RESET_R = 12'h001;
  localparam logic [17:0] RESET_N = 18'h0_000c;
  localparam logic [21:0] RESET_DEN = 22'h00_0001;
  localparam logic [2:0] RESET_ORDER = 3'h0;

  // Divide value limits against modulator order.
  localparam logic [17:0] N_MIN_1 = 18'h0_000c;
  localparam logic [17:0] N_MIN_2 = 18'h0_000d;
  localparam logic [17:0] N_MIN_3 = 18'h0_000f;
  localparam logic [17:0] N_MIN_4 = 18'h0_0013;
  localparam logic [11:0] N_MAX_1 = 12'hffe;
  localparam logic [11:0] N_MAX_2 = 12'hffd;
  localparam logic [11:0] N_MAX_3 = 12'hffb;
  localparam logic [11:0] N_MAX_4 = 12'hff7;

  // Calibration busy time.
  localparam int CLK_PERIOD_NS = 50;
  localparam int CAL_TIME_NS = 10000;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Settings the modulator needs from the register bank.
  typedef struct packed {
    logic frac_mode;
    logic [17:0] n_div;
    logic [21:0] num;
    logic [21:0] den;
  } fnd_mod_cfg_t;

endpackage

// ### fnd_regs.sv
// APB register bank and reference path of the fractional-N divider configuration.
// It assumes an APB master on pclk and asynchronous reference and keying pins.
// Overview of operation
// - Control bit enables binary keying on feedback.
// - Denominator is 22 bits in one word.
// - Writing lowest word starts VCO calibration; here only while int_vco is set.
// - Reference divider 1 to 4095; zero illegal.
// - Doubler on bypasses the reference divider.
// - Fractional mode uses twelve low divide bits.
// - Numerator split across two program words.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module fnd_regs (
  input wire logic pclk, // System clock, 20 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; all state holds while low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic reference_input, // Reference clock pin.
  input wire logic fsk_pin, // Keying data pin.
  output logic pd_tick, // Phase detector tick pulse.
  output logic [17:0] n_eff, // Feedback divide value in use.
  output logic vco_cal_start, // Calibration start pulse.
  output logic cal_busy, // Calibration running.
  output logic cfg_error // Programmed values out of range.
);

  logic [11:0] r_div;
  logic [17:0] n_div;
  logic [21:0] num;
  logic [21:0] frac_denominator;
  logic [2:0] order;
  logic doubler_en;
  logic int_vco;
  logic fsk_en;
  logic [2:0] ref_s;
  logic [2:0] fsk_s;
  logic fsk_lvl;
  logic ref_lvl;
  logic [11:0] ref_cnt;
  logic [7:0] cal_cnt;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic ref_rise;
  logic ref_any;
  logic fsk_step;
  logic [17:0] n_min;
  logic [11:0] n_max;
  logic next_error;
  fnd_pkg::fnd_mod_cfg_t mod_cfg;

  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign addr_ok = (paddr == fnd_pkg::ADDR_WORD0) || (paddr == fnd_pkg::ADDR_WORD1)
    || (paddr == fnd_pkg::ADDR_WORD2) || (paddr == fnd_pkg::ADDR_CTRL)
    || (paddr == fnd_pkg::ADDR_STATUS);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = ce && psel && penable && pwrite && addr_ok;
  assign rd_setup = ce && psel && !penable && !pwrite;

  // Program words; the divide value and numerator are each split over two words.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_div <= fnd_pkg::RESET_R;
      n_div <= fnd_pkg::RESET_N;
      num <= 22'h00_0000;
      frac_denominator <= fnd_pkg::RESET_DEN;
    end
    else if (wr_en)
    begin
      if (paddr == fnd_pkg::ADDR_WORD0)
      begin
        num[15:0] <= pwdata[fnd_pkg::W0_NUM_LO_LSB +: 16];
        n_div[11:0] <= pwdata[fnd_pkg::W0_N_LO_LSB +: 12];
      end
      if (paddr == fnd_pkg::ADDR_WORD1)
      begin
        r_div <= pwdata[fnd_pkg::W1_R_LSB +: 12];
        n_div[17:12] <= pwdata[fnd_pkg::W1_N_HI_LSB +: 6];
        num[21:16] <= pwdata[fnd_pkg::W1_NUM_HI_LSB +: 6];
      end
      if (paddr == fnd_pkg::ADDR_WORD2)
        frac_denominator <= pwdata[fnd_pkg::W2_DEN_LSB +: 22];
    end
  end

  // Control word: modulator order (zero means integer mode), doubler, VCO choice, keying.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      order <= fnd_pkg::RESET_ORDER;
      doubler_en <= 1'b0;
      int_vco <= 1'b1;
      fsk_en <= 1'b0;
    end
    else if (wr_en && paddr == fnd_pkg::ADDR_CTRL)
    begin
      order <= pwdata[fnd_pkg::CTRL_ORDER_LSB +: 3];
      doubler_en <= pwdata[fnd_pkg::CTRL_DOUBLER_BIT];
      int_vco <= pwdata[fnd_pkg::CTRL_INT_VCO_BIT];
      fsk_en <= pwdata[fnd_pkg::CTRL_FSK_BIT];
    end
  end

  // Read data is captured in the setup cycle so that it comes from a flip-flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
    begin
      case (paddr)
        fnd_pkg::ADDR_WORD0: prdata <= {4'h0, n_div[11:0], num[15:0]};
        fnd_pkg::ADDR_WORD1: prdata <= {8'h00, num[21:16], n_div[17:12], r_div};
        fnd_pkg::ADDR_WORD2: prdata <= {10'h000, frac_denominator};
        fnd_pkg::ADDR_CTRL: prdata <= {26'h000_0000, fsk_en, int_vco, doubler_en, order};
        fnd_pkg::ADDR_STATUS: prdata <= {30'h0000_0000, cfg_error, cal_busy};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Every write to the lowest word restarts calibration while int_vco is set, even with the same value.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vco_cal_start <= 1'b0;
      cal_cnt <= 8'h00;
      cal_busy <= 1'b0;
    end
    else if (ce)
    begin
      vco_cal_start <= wr_en && paddr == fnd_pkg::ADDR_WORD0 && int_vco;
      if (vco_cal_start)
      begin
        cal_cnt <= 8'(fnd_pkg::CAL_CYCLES - 1);
        cal_busy <= 1'b1;
      end
      else if (cal_cnt != 8'h00)
        cal_cnt <= cal_cnt - 8'h01;
      else
        cal_busy <= 1'b0;
    end
  end

  // Pin synchronisers; a change counts once the second and third stages agree.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_s <= 3'h0;
      fsk_s <= 3'h0;
      fsk_lvl <= 1'b0;
      ref_lvl <= 1'b0;
    end
    else if (ce)
    begin
      ref_s <= {ref_s[1:0], reference_input};
      fsk_s <= {fsk_s[1:0], fsk_pin};
      if (fsk_s[2] == fsk_s[1])
        fsk_lvl <= fsk_s[2];
      if (ref_s[2] == ref_s[1])
        ref_lvl <= ref_s[2];
    end
  end

  // An edge lasts one cycle: the agreed level differs from the level held so far.
  // A disagreement between the late stages never counts, so a metastable sample is ignored.
  assign ref_any = (ref_s[2] == ref_s[1]) && (ref_s[2] != ref_lvl);
  assign ref_rise = ref_any && ref_s[2];
  assign fsk_step = fsk_en && fsk_lvl;

  // Reference divider; the doubler takes both edges and skips the divider.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ref_cnt <= 12'h000;
      pd_tick <= 1'b0;
    end
    else if (ce)
    begin
      pd_tick <= 1'b0;
      if (doubler_en)
        pd_tick <= ref_any;
      else if (ref_rise)
      begin
        if (ref_cnt + 12'h001 >= r_div)
        begin
          ref_cnt <= 12'h000;
          pd_tick <= 1'b1;
        end
        else
          ref_cnt <= ref_cnt + 12'h001;
      end
    end
  end

  // Range check against the order-dependent limits and the fraction.
  always_comb
  begin
    case (order)
      3'h2: n_min = fnd_pkg::N_MIN_2;
      3'h3: n_min = fnd_pkg::N_MIN_3;
      3'h4: n_min = fnd_pkg::N_MIN_4;
      default: n_min = fnd_pkg::N_MIN_1;
    endcase
    case (order)
      3'h2: n_max = fnd_pkg::N_MAX_2;
      3'h3: n_max = fnd_pkg::N_MAX_3;
      3'h4: n_max = fnd_pkg::N_MAX_4;
      default: n_max = fnd_pkg::N_MAX_1;
    endcase
    next_error = (r_div == 12'h000);
    if (order == 3'h0)
      next_error = next_error || (n_div < n_min);
    else
      next_error = next_error || ({6'h00, n_div[11:0]} < n_min) || (n_div[11:0] > n_max)
        || (num > frac_denominator);
  end

  // Status flag follows the configuration one cycle later.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_error <= 1'b0;
    else if (ce)
      cfg_error <= next_error;
  end

  assign mod_cfg = '{frac_mode: order != 3'h0, n_div: n_div, num: num, den: frac_denominator};

  // The modulator is stepped on every phase detector tick.
  fnd_frac_mod u_mod (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .tick(pd_tick),
    .cfg(mod_cfg),
    .fsk_step(fsk_step),
    .n_eff(n_eff)
  );

  a_cal_on_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == fnd_pkg::ADDR_WORD0 && int_vco |=> vco_cal_start ##1 cal_busy)
    else $error("Lowest word write did not start calibration.");

  a_cal_only_vco: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !(wr_en && paddr == fnd_pkg::ADDR_WORD0 && int_vco) |=> !vco_cal_start)
    else $error("Calibration started without a lowest word write.");

  a_den_store: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == fnd_pkg::ADDR_WORD2 |=> frac_denominator == $past(pwdata[21:0]))
    else $error("Denominator not stored whole.");

  a_doubler_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    ce && doubler_en && ref_any |=> pd_tick)
    else $error("Doubler did not bypass the divider.");

  a_fsk_off: assert property (@(posedge pclk) disable iff (!presetn)
    ce && pd_tick && order == 3'h0 && !fsk_en |=> n_eff == $past(n_div))
    else $error("Keying changed the divide value while disabled.");

  a_r_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ce && r_div == 12'h000 |=> cfg_error)
    else $error("Zero reference divider not flagged.");

  a_num_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ce && order != 3'h0 && num > frac_denominator |=> cfg_error)
    else $error("Numerator above denominator not flagged.");

  a_n_min_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ce && order == 3'h0 && n_div < fnd_pkg::N_MIN_1 |=> cfg_error)
    else $error("Divide value below minimum not flagged.");

endmodule

// ### tb_top.sv
// Self-checking bench for the divider configuration bank, with a register model.
// It assumes the host model above and a reference pin toggled every four cycles.
`timescale 1ns/100ps
module tb_top;
  logic pclk, presetn, ce, go, wr, ref_in, fsk, psel, penable, pwrite, pready, pslverr;
  logic done, err, pd_tick, cal_start, cal_busy, cfg_error, tick_d;
  logic [7:0] ad, paddr;
  logic [31:0] wd, rd, pwdata, prdata;
  logic [17:0] n_eff;
  logic [17:0] nq[$];
  int gq[$];
  int miscompares = 0, total_checks = 0, seed = 23, cyc = 0, last = 0, pulses = 0, busy = 0;
  int rc = 0, r_s = 1, n_s = 12, num_s = 0, den_s = 1, ctl_s = 'h10, i, j, o, p, b, s;
  int mn[5] = '{12, 12, 13, 15, 19};
  int mx[5] = '{0, 4094, 4093, 4091, 4087};
  fnd_regs DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reference_input(ref_in), .fsk_pin(fsk), .pd_tick(pd_tick),
    .n_eff(n_eff), .vco_cal_start(cal_start), .cal_busy(cal_busy), .cfg_error(cfg_error));
  fnd_host_model u_host (.pclk(pclk), .presetn(presetn), .go(go), .wr(wr), .addr(ad),
    .wdata(wd), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .done(done),
    .rdata(rd), .err(err));
  // The clock runs at 20 MHz.
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Monitor: tick spacing, divide values, calibration pulses and busy cycles; reference pin.
  always @(posedge pclk)
  begin
    cyc++;
    rc++;
    if (presetn !== 1'b1)
      ref_in <= 1'b0;
    else if (rc % 4 == 0)
      ref_in <= ~ref_in;
    pulses += (cal_start === 1'b1);
    busy += (cal_busy === 1'b1);
    tick_d <= pd_tick;
    if (pd_tick === 1'b1)
    begin
      gq.push_back(cyc - last);
      last = cyc;
    end
    if (tick_d === 1'b1) nq.push_back(n_eff);
  end
  // Model of the register contents, built from the shadow fields.
  function automatic logic [31:0] ex(input int a);
    case (a)
      0: return {4'h0, n_s[11:0], num_s[15:0]};
      4: return {8'h00, num_s[21:16], n_s[17:12], r_s[11:0]};
      8: return {10'h000, den_s[21:0]};
      12: return ctl_s;
      default: return 32'h0000_0000;
    endcase
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One transfer through the host model; the two edges let go and done settle.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    go <= 1'b1;
    wr <= w;
    ad <= a;
    wd <= d;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    for (k = 0; k < 20 && done !== 1'b1; k++) @(posedge pclk);
    if (done !== 1'b1)
    begin
      miscompares++;
      $display("[ERR] apb done expected 1 seen %b", done);
      wrap_up;
    end
  endtask
  task rdchk(input int a);
    apb(1'b0, a[7:0], 32'h0000_0000);
    chk("prdata", ex(a), rd);
  endtask
  // Writes every program word and the control word from the shadows.
  task cfg;
    apb(1'b1, 8'h04, ex(4));
    apb(1'b1, 8'h00, ex(0));
    apb(1'b1, 8'h08, ex(8));
    apb(1'b1, 8'h0c, ex(12));
  endtask
  task errchk(input logic e);
    repeat (3) @(posedge pclk);
    chk("cfg_error", e, cfg_error);
  endtask
  task wtick(input int n);
    int k, m;
    k = nq.size();
    for (m = 0; m < 9000 && nq.size() < k + n; m++) @(posedge pclk);
    if (nq.size() < k + n)
    begin
      miscompares++;
      $display("[ERR] ticks expected %0d seen %0d", k + n, nq.size());
      wrap_up;
    end
  endtask
  // Main sequence; waits are bounded, so a hang ends in the closing report.
  initial
  begin
    presetn = 1'b0;
    ce = 1'b1;
    go = 1'b0;
    wr = 1'b0;
    ad = 8'h00;
    wd = 32'h0000_0000;
    fsk = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i <= 16; i += 4) rdchk(i);
    // A read of the unmapped address 0x14 must return pslverr and zero read data.
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("pslverr", 1'b1, err);
    chk("rd unmapped", 32'h0000_0000, rd);
    for (j = 0; j < 3; j++)
    begin
      for (i = 0; i < 300 && cal_busy !== 1'b0; i++) @(posedge pclk);
      if (cal_busy !== 1'b0)
      begin
        miscompares++;
        $display("[ERR] cal_busy expected 0 seen %b", cal_busy);
        wrap_up;
      end
      p = pulses;
      b = busy;
      if (j == 2)
      begin
        ctl_s = 'h00;
        apb(1'b1, 8'h0c, ex(12));
      end
      apb(1'b1, 8'h00, ex(0));
      repeat (210) @(posedge pclk);
      chk("cal pulses", p + (j < 2), pulses);
      chk("busy cycles", b + (j < 2) * 200, busy);
    end
    for (j = 0; j < 3; j++)
    begin
      r_s = 1 + $unsigned($random(seed)) % 4;
      n_s = 12 + $unsigned($random(seed)) % 200000;
      ctl_s = 'h00;
      fsk <= 1'b1;
      cfg;
      wtick(4);
      chk("tick gap", 8 * r_s, gq[$]);
      chk("n_eff int", n_s, nq[$]);
      ctl_s = 'h20;
      apb(1'b1, 8'h0c, ex(12));
      wtick(3);
      chk("n_eff keyed", n_s + 1, nq[$]);
      ctl_s = 'h08;
      fsk <= 1'b0;
      apb(1'b1, 8'h0c, ex(12));
      wtick(4);
      chk("tick gap dbl", 4, gq[$]);
    end
    r_s = 0;
    ctl_s = 'h00;
    cfg;
    errchk(1'b1);
    r_s = 1;
    for (o = 0; o < 5; o++)
    begin
      ctl_s = o;
      den_s = 7;
      n_s = mn[o] - 1;
      cfg;
      errchk(1'b1);
      n_s = mn[o];
      cfg;
      errchk(1'b0);
      if (o > 0)
      begin
        n_s = mx[o] + 1;
        cfg;
        errchk(1'b1);
        n_s = mx[o] + 'h1000;
        cfg;
        errchk(1'b0);
      end
    end
    ctl_s = 1;
    n_s = 100;
    num_s = 8;
    cfg;
    errchk(1'b1);
    for (j = 0; j < 3; j++)
    begin
      den_s = 5 + $unsigned($random(seed)) % 20;
      num_s = $unsigned($random(seed)) % (den_s + 1);
      n_s = 'h3_0000 + 100 + $unsigned($random(seed)) % 500;
      cfg;
      errchk(1'b0);
      // Leave room for a leftover accumulator to drain below the new denominator.
      wtick(den_s + 100);
      s = 0;
      for (i = nq.size() - den_s; i < nq.size(); i++) s += nq[i];
      chk("frac sum", den_s * (n_s % 4096) + num_s, s);
    end
    num_s = 'h2a_5555;
    den_s = 4194303;
    cfg;
    rdchk(0);
    rdchk(4);
    apb(1'b1, 8'h08, 32'hffff_ffff);
    rdchk(8);
    errchk(1'b0);
    // A write while the clock enable is low must be ignored, so the denominator stays.
    ce <= 1'b0;
    apb(1'b1, 8'h08, 32'h0000_0005);
    ce <= 1'b1;
    rdchk(8);
    wrap_up;
  end
endmodule
